// [idstat_pkg.sv]
// Constants and types for the primary identification and status registers
// Functional notes
// - Bits 15:4 of the identity word hold a fixed, read-only chip version code that writes cannot change.
// - Bit 1 of the identity and status words reports whether the previous serial message was processed (0) or discarded (1).
// - Bit 0 of the identity and status words is an odd parity bit for that word; unmapped words read as 0x0000.
// - Status bit 11 is the OR of all bits of the primary error register.
// - Status bits 9:8 hold the latest turn-on plateau request, coded as the turn-on plateau control field.
// - Status bits 5:2 hold the latest regular turn-off plateau request, coded as the turn-off control field.
// - Status bit 7 is 1 when the operating mode taken at the latest update was the active mode (code 4).
// - Status bit 6 is 1 when the secondary chip is ready and 0 when it is not.
// - Each address selects one whole 16-bit word; there is no byte access.
package idstat_pkg;

  localparam logic [7:0]  ADDR_IDENTITY  = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h01;
  localparam logic [15:0] STATUS_RESET   = 16'h087D;
  // Version code value is arbitrary
  localparam logic [11:0] CHIP_VERSION   = 12'h5C1;
  localparam logic [2:0]  ACTIVE_MODE_CODE = 3'h4;

  localparam int          POS_VERSION    = 4;
  localparam int          POS_ERR        = 11;
  localparam int          POS_TURN_ON    = 8;
  localparam int          POS_ACTIVE     = 7;
  localparam int          POS_SEC_READY  = 6;
  localparam int          POS_TURN_OFF   = 2;
  localparam int          POS_DISCARD    = 1;
  localparam int          POS_PARITY     = 0;

  typedef struct packed {
    logic [15:0] primary_error_reg;
    logic [1:0]  turn_on_plateau_status;
    logic [3:0]  turn_off_plateau_status;
    logic [2:0]  operating_mode;
    logic        secondary_ready_flag;
    logic        last_msg_discarded;
  } status_src_t;

endpackage : idstat_pkg

// [odd_parity.sv]
// Odd parity generator for a 15-bit payload
`timescale 1ns/10ps
module odd_parity (
  input  wire logic [14:0] i_data,
  output logic             o_par
);
  assign o_par = ~(^i_data);
endmodule : odd_parity

// [primary_id_status_regs.sv]
// Primary identity and status register bank with parity
`timescale 1ns/10ps
module primary_id_status_regs (
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_rd,
  input  wire logic [7:0]               i_addr,
  input  wire idstat_pkg::status_src_t  i_src,
  input  wire logic                     i_upd,
  output logic [15:0]                   o_rdata,
  output logic                          o_rvalid
);

  // Target of the read taken at this edge
  typedef enum logic [1:0] {
    READ_NONE     = 2'h0,
    READ_IDENTITY = 2'h1,
    READ_STATUS   = 2'h2,
    READ_UNMAPPED = 2'h3
  } read_sel_t;

  logic        rstn_s1_reg;
  logic        rstn_s1_next;
  logic        rstn_sync_reg;
  logic        rstn_sync_next;

  logic        err_any;
  logic        active_now;

  logic        err_reg;
  logic        err_next;
  logic [1:0]  turn_on_reg;
  logic [1:0]  turn_on_next;
  logic        active_reg;
  logic        active_next;
  logic        sec_ready_reg;
  logic        sec_ready_next;
  logic [3:0]  turn_off_reg;
  logic [3:0]  turn_off_next;

  logic [15:0] status_view;
  logic [14:0] id_payload;
  logic [14:0] st_payload;
  logic        id_par;
  logic        st_par;
  logic [15:0] id_word;
  logic [15:0] st_word;

  read_sel_t   read_sel;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;

  always_comb begin
    rstn_s1_next   = 1'h1;
    rstn_sync_next = rstn_s1_reg;
  end

  // Two flops keep a late release from reaching the design on a metastable edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rstn_s1_reg   <= 1'h0;
      rstn_sync_reg <= 1'h0;
    end else begin
      rstn_s1_reg   <= rstn_s1_next;
      rstn_sync_reg <= rstn_sync_next;
    end
  end

  always_comb begin
    err_any = |i_src.primary_error_reg;
  end

  always_comb begin
    case (i_src.operating_mode)
      idstat_pkg::ACTIVE_MODE_CODE: begin
        active_now = 1'h1;
      end
      default: begin
        active_now = 1'h0;
      end
    endcase
  end

  // Fields follow their sources only on an update, so they hold between updates; status bit 1 (discard) stays live
  always_comb begin
    err_next       = err_reg;
    turn_on_next   = turn_on_reg;
    active_next    = active_reg;
    sec_ready_next = sec_ready_reg;
    turn_off_next  = turn_off_reg;
    if (i_upd) begin
      err_next       = err_any;
      turn_on_next   = i_src.turn_on_plateau_status;
      active_next    = active_now;
      sec_ready_next = i_src.secondary_ready_flag;
      turn_off_next  = i_src.turn_off_plateau_status;
    end
  end

  always_ff @(posedge i_clk or negedge rstn_sync_reg) begin
    if (!rstn_sync_reg) begin
      err_reg       <= idstat_pkg::STATUS_RESET[idstat_pkg::POS_ERR];
      turn_on_reg   <= idstat_pkg::STATUS_RESET[idstat_pkg::POS_TURN_ON +: 2];
      active_reg    <= idstat_pkg::STATUS_RESET[idstat_pkg::POS_ACTIVE];
      sec_ready_reg <= idstat_pkg::STATUS_RESET[idstat_pkg::POS_SEC_READY];
      turn_off_reg  <= idstat_pkg::STATUS_RESET[idstat_pkg::POS_TURN_OFF +: 4];
    end else begin
      err_reg       <= err_next;
      turn_on_reg   <= turn_on_next;
      active_reg    <= active_next;
      sec_ready_reg <= sec_ready_next;
      turn_off_reg  <= turn_off_next;
    end
  end

  always_comb begin
    status_view = 16'h0000;
    status_view[idstat_pkg::POS_ERR] = err_reg;
    status_view[idstat_pkg::POS_TURN_ON +: 2] = turn_on_reg;
    status_view[idstat_pkg::POS_ACTIVE] = active_reg;
    status_view[idstat_pkg::POS_SEC_READY] = sec_ready_reg;
    status_view[idstat_pkg::POS_TURN_OFF +: 4] = turn_off_reg;
    status_view[idstat_pkg::POS_DISCARD] = i_src.last_msg_discarded;
  end

  always_comb begin
    id_payload = {idstat_pkg::CHIP_VERSION, 2'h0, i_src.last_msg_discarded};
  end

  always_comb begin
    st_payload = status_view[15:1];
  end

  odd_parity u_par_id (
    .i_data (id_payload),
    .o_par  (id_par)
  );

  odd_parity u_par_st (
    .i_data (st_payload),
    .o_par  (st_par)
  );

  always_comb begin
    id_word = {id_payload, id_par};
  end

  always_comb begin
    st_word = {st_payload, st_par};
  end

  always_comb begin
    read_sel = READ_NONE;
    if (i_rd) begin
      case (i_addr)
        idstat_pkg::ADDR_IDENTITY: begin
          read_sel = READ_IDENTITY;
        end
        idstat_pkg::ADDR_STATUS: begin
          read_sel = READ_STATUS;
        end
        default: begin
          read_sel = READ_UNMAPPED;
        end
      endcase
    end
  end

  // no write path, so no bit can be written
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = 1'h0;
    case (read_sel)
      READ_IDENTITY: begin
        rvalid_next = 1'h1;
        rdata_next  = id_word;
      end
      READ_STATUS: begin
        rvalid_next = 1'h1;
        rdata_next  = st_word;
      end
      // Unmapped words still answer, so a host never waits on them
      READ_UNMAPPED: begin
        rvalid_next = 1'h1;
        rdata_next  = 16'h0000;
      end
      default: begin
        rvalid_next = 1'h0;
        rdata_next  = rdata_reg;
      end
    endcase
  end

  // Read data stands until the next read, so a slow host may still pick it up
  always_ff @(posedge i_clk or negedge rstn_sync_reg) begin
    if (!rstn_sync_reg) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'h0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_rdata  = rdata_reg;
  assign o_rvalid = rvalid_reg;

endmodule : primary_id_status_regs

// [idstat_chk.sv]
// Checker for the register read port
`timescale 1ns/10ps
module idstat_chk (
  input wire logic                    i_clk,
  input wire logic                    i_rstn,
  input wire logic                    i_rd,
  input wire logic [7:0]              i_addr,
  input wire idstat_pkg::status_src_t i_src,
  input wire logic                    i_upd,
  input wire logic [15:0]             o_rdata,
  input wire logic                    o_rvalid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  read_answer_a: assert property (i_rd |=> o_rvalid) else $error("no answer");
  idle_hold_a: assert property (!i_rd |=> !o_rvalid && $stable(o_rdata)) else $error("moved");
  odd_parity_a: assert property (i_rd && i_addr < 8'h02 |=> ^o_rdata) else $error("parity");
  id_word_a: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[15:2] == 14'h1704)
    else $error("bad id");
  discard_live_a: assert property (i_rd && i_addr < 8'h02 |=> o_rdata[1] == $past(i_src[0]))
    else $error("bad discard flag");
  stat_zero_a: assert property (i_rd && i_addr == 8'h01 |=> o_rdata[15:12] == 4'h0 && !o_rdata[10])
    else $error("bad zero");
  err_mode_a: assert property (i_upd ##1 !i_upd ##1 !i_upd && i_rd && i_addr == 8'h01 |=>
    o_rdata[11] == |$past(i_src[26:11], 3) && o_rdata[7] == ($past(i_src[4:2], 3) == 3'h4))
    else $error("bad err");
  plateau_ready_a: assert property (i_upd ##1 !i_upd ##1
    !i_upd && i_rd && i_addr == 8'h01 |=> o_rdata[9:8] == $past(i_src[10:9], 3) &&
    o_rdata[5:2] == $past(i_src[8:5], 3) && o_rdata[6] == $past(i_src[1], 3))
    else $error("bad plateau");
  unmapped_a: assert property (i_rd && i_addr > 8'h01 |=> o_rdata == 16'h0000) else $error("unmapped");
endmodule : idstat_chk
bind primary_id_status_regs idstat_chk chk_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_rd(i_rd),
  .i_addr(i_addr), .i_src(i_src), .i_upd(i_upd), .o_rdata(o_rdata), .o_rvalid(o_rvalid));

// [host_rd.sv]
// Host model issuing word reads
`timescale 1ns/10ps
module host_rd (
  input  wire logic        i_clk,
  input  wire logic        i_rv,
  input  wire logic [15:0] i_rdata,
  output logic             o_rd,
  output logic [7:0]       o_addr
);
  initial begin
    o_rd = 1'h0;
    o_addr = 8'h00;
  end
  task automatic rd(input logic [7:0] a, output logic [16:0] d);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = {i_rv, i_rdata};
  endtask : rd
endmodule : host_rd

// [primary_id_status_regs_test.sv]
// Bench for the identity and status registers
`timescale 1ns/10ps
module primary_id_status_regs_test;
  logic clk = 1'b0, rstn = 1'b0, upd = 1'b0, rd, rv;
  logic [7:0] addr;
  logic [15:0] rdata;
  idstat_pkg::status_src_t src = '0;
  int fails = 0, num_checks = 0;
  always #25 clk = ~clk;
  primary_id_status_regs uut (.i_clk(clk), .i_rstn(rstn), .i_rd(rd), .i_addr(addr),
    .i_src(src), .i_upd(upd), .o_rdata(rdata), .o_rvalid(rv));
  host_rd host (.i_clk(clk), .i_rv(rv), .i_rdata(rdata), .o_rd(rd), .o_addr(addr));
  function automatic logic [15:0] par(input logic [15:0] w);
    return {w[15:1], ~^w[15:1]};
  endfunction : par
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    logic [16:0] d;
    host.rd(a, d);
    num_checks++;
    if (d !== {1'b1, e}) begin
      fails++;
      $display("CHECK FAILED %0t addr %h got %h", $time, a, d);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #200us;
    fails++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'h01, idstat_pkg::STATUS_RESET);
    chk(8'h00, par({idstat_pkg::CHIP_VERSION, 4'h0}));
    src.last_msg_discarded = 1'b1;
    chk(8'h01, par(16'h087E));
    chk(8'h02, 16'h0000);
    $display("reset test done");
    for (int m = 0; m < 8; m++) begin
      @(negedge clk);
      src = '{(m == 0) ? 16'h0000 : 16'h0001 << (m + 7), 2'(m), 4'(m) ^ 4'hA, 3'(m), m[0], m[1]};
      upd = 1'b1;
      @(negedge clk);
      upd = 1'b0;
      src = {~src[26:1], m[1]};
      chk(8'h01, par({4'h0, m != 0, 1'b0, 2'(m), m == 4, m[0], 4'(m) ^ 4'hA, m[1], 1'b0}));
    end
    chk(8'h00, par({idstat_pkg::CHIP_VERSION, 4'h2}));
    $display("update test done");
    @(negedge clk);
    rstn = 1'b0;
    src = '0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'h01, idstat_pkg::STATUS_RESET);
    $display("second reset test done");
    final_report();
  end
endmodule : primary_id_status_regs_test
